/* common/hps_pkg.sv */
package hps_pkg;

    // Register offsets on the serial register bus.
    localparam logic [7:0] MODE_CTRL_ADDR   = 8'h01;
    localparam logic [7:0] RT_DRIVE_ADDR    = 8'h02;
    localparam logic [7:0] FLOAT_CTRL_ADDR  = 8'h03;
    localparam logic [7:0] SLOT_FIRST_ADDR  = 8'h04;
    localparam logic [7:0] SLOT_LAST_ADDR   = 8'h0b;
    localparam logic [7:0] FIRE_ADDR        = 8'h0c;
    localparam logic [7:0] FORMAT_CTRL_ADDR = 8'h1d;

    // Field positions.
    localparam int STANDBY_BIT   = 6;
    localparam int MODE_LSB      = 0;
    localparam int MODE_W        = 3;
    localparam int FLOAT_BIT     = 4;
    localparam int FIRE_BIT      = 0;
    localparam int UNSIGNED_BIT  = 3;
    localparam int SLOT_WAIT_BIT = 7;
    localparam int SLOT_VAL_W    = 7;

    // Mode selector values.
    localparam logic [2:0] MODE_INTERNAL = 3'h0;
    localparam logic [2:0] MODE_REALTIME = 3'h5;

    // Values after reset.
    localparam logic [7:0] RT_DRIVE_RESET = 8'h00;
    localparam logic [7:0] SLOT_RESET     = 8'h00;
    localparam logic [2:0] MODE_RESET     = 3'h0;
    localparam logic       STANDBY_RESET  = 1'b1;

    // Sequencer size.
    localparam int SLOT_COUNT = 8;
    localparam int SLOT_IDX_W = 3;

    // Wait unit timing.
    localparam int CLK_HZ           = 100_000_000;
    localparam int WAIT_UNIT_MS     = 10;
    localparam int WAIT_UNIT_CYCLES = (CLK_HZ / 1000) * WAIT_UNIT_MS;

endpackage

/* core/hps_sequencer.sv */
`timescale 1ns/1ps
// Overview of operation
// - In mode 5 the drive output continuously carries the real-time drive value register.
// - Each host rewrite of the real-time drive value reaches the output with no trigger.
// - The drive value is signed by default and unsigned when the format bit in 0x1D is set.
// - Bit 4 of the float register puts the output driver into high impedance.
// - Float only applies while enabled; in shutdown or standby the outputs are pulled to ground.
// - The float bit acts at once, even in the middle of playback.
// - Eight slot registers at 0x04 to 0x0B each hold a wait flag in bit 7 and a 7-bit value.
// - A wait slot idles for 10 ms times its value before moving on.
// - A non-wait slot plays the library waveform whose index is its value.
// - Setting the fire bit in 0x0C starts playback at slot 0x04.
// - After a slot the sequencer moves to the next slot if its value is non-zero.
// - The sequencer stops at a zero slot or after the slot at 0x0B, whichever is first.
// - The fire bit stays high until the sequence ends and then self-clears; clearing it cancels.
// - Mode value 5 selects real-time playback driven from the drive value register.
// - The standby bit set to 1 puts the device in software standby, 0 makes it ready.
module hps_sequencer #(
    parameter int WAIT_UNIT_CYCLES = hps_pkg::WAIT_UNIT_CYCLES
) (
    input  logic       clk,
    input  logic       resetn,
    input  logic       hw_enable,
    input  logic [7:0] reg_addr,
    input  logic [7:0] reg_wdata,
    input  logic       reg_we,
    input  logic       reg_re,
    output logic [7:0] reg_rdata,
    output logic       reg_rvalid,
    output logic [7:0] drive_value,
    output logic       drive_unsigned,
    output logic       drive_active,
    output logic       out_float,
    output logic       out_pulldown,
    output logic       lib_start,
    output logic [6:0] lib_index,
    output logic       lib_abort,
    input  logic       lib_done,
    output logic       seq_busy
);

    // Elaboration checks: a wait unit of zero cycles would end every wait slot at once,
    // and the slot index must address exactly the eight slot registers, no more, no less.
    // Either mistake would build without complaint and misbehave, so both are refused here.
    if (WAIT_UNIT_CYCLES < 1) begin : g_bad_wait_unit
        $error("WAIT_UNIT_CYCLES must be at least one");
    end
    if ((1 << hps_pkg::SLOT_IDX_W) != hps_pkg::SLOT_COUNT) begin : g_bad_slot_index
        $error("SLOT_IDX_W does not match SLOT_COUNT");
    end

    // Sequencer states. IDLE waits for the fire bit, FETCH looks at the current slot,
    // PLAY waits for the library player to finish, and WAIT counts out a timed pause.
    // Every state can fall back to IDLE at once when the host or the context cancels.
    typedef enum logic [1:0] {
        HPS_IDLE,
        HPS_FETCH,
        HPS_PLAY,
        HPS_WAIT
    } hps_state_type;

    localparam int CNT_W = $clog2(WAIT_UNIT_CYCLES + 1);

    // True when an address falls inside the eight slot registers.
    function automatic logic is_slot_addr(input logic [7:0] addr);
        return (addr >= hps_pkg::SLOT_FIRST_ADDR) && (addr <= hps_pkg::SLOT_LAST_ADDR);
    endfunction

    // Slot number of an address in the slot range; the upper bits are dropped on purpose.
    function automatic logic [hps_pkg::SLOT_IDX_W-1:0] slot_of(input logic [7:0] addr);
        logic [7:0] offset;
        offset = addr - hps_pkg::SLOT_FIRST_ADDR;
        return offset[hps_pkg::SLOT_IDX_W-1:0];
    endfunction

    // Seven-bit value field of a slot byte, a waveform index or a count of wait units.
    function automatic logic [6:0] slot_value(input logic [7:0] slot);
        return slot[hps_pkg::SLOT_VAL_W-1:0];
    endfunction

    // Register copies of the host-visible fields, the sequencer state, and the strobes
    // decoded from the register bus that several processes share.
    logic                         rst_meta_q;
    logic                         rst_sync_q;
    logic                         rst_n;
    logic [7:0]                   rt_drive_q;
    logic [2:0]                   mode_q;
    logic                         standby_q;
    logic                         float_q;
    logic                         unsigned_q;
    logic                         fire_q;
    logic [7:0]                   slot_q [hps_pkg::SLOT_COUNT];
    hps_state_type                state_q;
    logic [hps_pkg::SLOT_IDX_W-1:0] idx_q;
    logic [6:0]                   units_q;
    logic [CNT_W-1:0]             cyc_q;
    logic [7:0]                   cur_slot;
    logic                         slot_write;
    logic [hps_pkg::SLOT_IDX_W-1:0] slot_widx;
    logic                         fire_write;
    logic                         host_cancel;
    logic                         ctx_cancel;
    logic                         seq_end;
    logic                         slot_finish;

    // Reset release goes through two flip-flops; only the second is used.
    // The reset pin may rise at any moment relative to the clock, so the rest of
    // the block leaves reset only on a clean edge of the second flip-flop.
    // Assertion of reset is still immediate because both flip-flops clear at once.
    // Nothing but the second flip-flop reads the first, to keep the path short.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // Decode of write strobes used by more than one process.
    // A write of zero to the fire register is the host's cancel request; it is kept
    // apart from the context cancel so that a waveform in flight can be aborted
    // whichever of the two stops it. Slot writes are accepted at any time, also
    // during playback, and take effect when the sequencer next fetches that slot.
    assign slot_write = reg_we && is_slot_addr(reg_addr);
    assign slot_widx  = slot_of(reg_addr);
    assign fire_write = reg_we && (reg_addr == hps_pkg::FIRE_ADDR);
    assign host_cancel = fire_write && !reg_wdata[hps_pkg::FIRE_BIT];
    // Leaving internal-trigger mode or entering standby also stops the sequence.
    // A pulled-low enable pin is treated the same way: with the output stage shut
    // down there is nothing for the sequence to drive, so it is dropped, not paused.
    // The host must fire again once the device is ready.
    assign ctx_cancel  = standby_q || (mode_q != hps_pkg::MODE_INTERNAL) || !hw_enable;
    assign cur_slot    = slot_q[idx_q];

    // Control registers: drive value, mode, standby, float and format.
    // Each write lands on the clock edge that takes it and is seen by the output
    // stage in the next cycle, so a host stream of drive values reaches the load
    // one sample at a time with no further trigger. Writes to addresses that hold
    // none of these fields are ignored here; the slot writes are handled below.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rt_drive_q <= hps_pkg::RT_DRIVE_RESET;
            mode_q     <= hps_pkg::MODE_RESET;
            standby_q  <= hps_pkg::STANDBY_RESET;
            float_q    <= 1'b0;
            unsigned_q <= 1'b0;
        end else if (reg_we) begin
            unique case (reg_addr)
                hps_pkg::RT_DRIVE_ADDR: begin
                    rt_drive_q <= reg_wdata;
                end
                hps_pkg::MODE_CTRL_ADDR: begin
                    mode_q    <= reg_wdata[hps_pkg::MODE_LSB +: hps_pkg::MODE_W];
                    standby_q <= reg_wdata[hps_pkg::STANDBY_BIT];
                end
                hps_pkg::FLOAT_CTRL_ADDR: begin
                    float_q <= reg_wdata[hps_pkg::FLOAT_BIT];
                end
                hps_pkg::FORMAT_CTRL_ADDR: begin
                    unsigned_q <= reg_wdata[hps_pkg::UNSIGNED_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Slot storage, one byte per slot.
    // The whole byte is kept: bit 7 selects wait or play and the low seven bits
    // carry the value, and all eight bits read back as written.
    // Storage is plain flip-flops addressed by the slot number.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < hps_pkg::SLOT_COUNT; i++) begin
                slot_q[i] <= hps_pkg::SLOT_RESET;
            end
        end else if (slot_write) begin
            slot_q[slot_widx] <= reg_wdata;
        end
    end

    // The current slot ends when its waveform or its wait completes.
    // A done pulse from the library player outside PLAY is ignored, so a late pulse
    // after an abort cannot advance the walk. A wait ends when its unit count runs
    // out; a wait of zero units never reaches WAIT because it terminates the sequence.
    assign slot_finish = ((state_q == HPS_PLAY) && lib_done)
                         || ((state_q == HPS_WAIT) && (units_q == 7'h00));
    // The sequence ends at a zero slot, wait or not, or after the last slot.
    assign seq_end = ((state_q == HPS_FETCH)
                      && (slot_value(cur_slot) == 7'h00))
                     || (slot_finish && (idx_q == 3'h7));

    // Fire bit: host sets it, hardware clears it at the end; a host write wins.
    // When a write of one and the end of a sequence fall in one cycle, the bit stays
    // set and a fresh sequence starts from the first slot on the next idle cycle.
    // A write of one while the device is not in internal-trigger mode, or is in
    // standby or shutdown, is cleared again one cycle later, so the host can read
    // back that the request was not taken.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_q <= 1'b0;
        end else if (fire_write) begin
            fire_q <= reg_wdata[hps_pkg::FIRE_BIT];
        end else if (seq_end || ctx_cancel) begin
            fire_q <= 1'b0;
        end
    end

    // Sequencer walk through the eight slots.
    // Every slot, wait or play, takes one FETCH cycle before its action, and the
    // index moves on only once that action has finished. The walk ends at a slot
    // whose value is zero or after the last slot, whichever comes first; the fire
    // bit is cleared in the same cycle. A cancel from any source wins over all else
    // outside IDLE and returns to IDLE in one cycle, leaving the slot contents untouched;
    // in IDLE only the context cancel holds back a start pending on the fire bit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HPS_IDLE;
            idx_q   <= '0;
        end else if ((state_q != HPS_IDLE) && (host_cancel || ctx_cancel)) begin
            state_q <= HPS_IDLE;
        end else begin
            unique case (state_q)
                HPS_IDLE: begin
                    if (fire_q && !ctx_cancel) begin
                        idx_q   <= '0;
                        state_q <= HPS_FETCH;
                    end
                end
                HPS_FETCH: begin
                    if (seq_end) begin
                        state_q <= HPS_IDLE;
                    end else if (cur_slot[hps_pkg::SLOT_WAIT_BIT]) begin
                        state_q <= HPS_WAIT;
                    end else begin
                        state_q <= HPS_PLAY;
                    end
                end
                HPS_PLAY, HPS_WAIT: begin
                    if (seq_end) begin
                        state_q <= HPS_IDLE;
                    end else if (slot_finish) begin
                        idx_q   <= idx_q + 3'h1;
                        state_q <= HPS_FETCH;
                    end
                end
            endcase
        end
    end

    // Wait timer: units of WAIT_UNIT_CYCLES clock cycles.
    // The unit count and the cycle count are both loaded in FETCH, so a wait slot
    // lasts its value times the unit, plus the fetch and one cycle to see the end.
    // At the default unit one count is ten milliseconds; a smaller unit only
    // shortens simulation and changes nothing else in the walk.
    // The counters hold their value outside FETCH and WAIT, which costs no extra logic.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            units_q <= 7'h00;
            cyc_q   <= '0;
        end else if (state_q == HPS_FETCH) begin
            units_q <= slot_value(cur_slot);
            cyc_q   <= CNT_W'(WAIT_UNIT_CYCLES - 1);
        end else if ((state_q == HPS_WAIT) && (units_q != 7'h00)) begin
            if (cyc_q == '0) begin
                units_q <= units_q - 7'h01;
                cyc_q   <= CNT_W'(WAIT_UNIT_CYCLES - 1);
            end else begin
                cyc_q <= cyc_q - CNT_W'(1);
            end
        end
    end

    // Library requests: one pulse to start, one pulse to abort.
    // The start pulse is suppressed when a cancel arrives in the fetch cycle, so the
    // library player never sees a start that would at once have to be aborted.
    // The waveform index stays on its port until the next fetch, so the player may
    // take it at any time after the start pulse. An abort is sent only from PLAY,
    // because in the other states no waveform is running.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lib_start <= 1'b0;
            lib_index <= 7'h00;
            lib_abort <= 1'b0;
        end else begin
            lib_start <= (state_q == HPS_FETCH) && !seq_end && !host_cancel && !ctx_cancel
                         && !cur_slot[hps_pkg::SLOT_WAIT_BIT];
            if (state_q == HPS_FETCH) begin
                lib_index <= slot_value(cur_slot);
            end
            lib_abort <= (state_q == HPS_PLAY) && (host_cancel || ctx_cancel);
        end
    end

    // Read port answers one cycle after the strobe; unmapped reads give zero.
    // Reserved bits of every register read back as zero. A read and a write to
    // the same register in one cycle return the value from before the write.
    // The read data holds until the next read, so a slow host may take it late.
    // The valid flag is a one-cycle pulse and marks the cycle the data is new.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_re;
            if (reg_re) begin
                if (is_slot_addr(reg_addr)) begin
                    reg_rdata <= slot_q[slot_of(reg_addr)];
                end else begin
                    unique case (reg_addr)
                        hps_pkg::MODE_CTRL_ADDR:
                            reg_rdata <= {1'b0, standby_q, 3'h0, mode_q};
                        hps_pkg::RT_DRIVE_ADDR:
                            reg_rdata <= rt_drive_q;
                        hps_pkg::FLOAT_CTRL_ADDR:
                            reg_rdata <= {3'h0, float_q, 4'h0};
                        hps_pkg::FIRE_ADDR:
                            reg_rdata <= {7'h00, fire_q};
                        hps_pkg::FORMAT_CTRL_ADDR:
                            reg_rdata <= {4'h0, unsigned_q, 3'h0};
                        default:
                            reg_rdata <= 8'h00;
                    endcase
                end
            end
        end
    end

    // Output stage: registered drive value, combinational mode qualifiers.
    // The float request and the pull to ground never stand together: float needs an
    // enabled device, and the pull path is used in shutdown or standby. Float also
    // takes away the active drive in the cycle after the float bit is written,
    // even while a waveform is playing, so the output stops driving the load at once.
    // The sequence keeps its place in that case; only the output stage is released.
    assign drive_value    = rt_drive_q;
    assign drive_unsigned = unsigned_q;
    assign drive_active   = (mode_q == hps_pkg::MODE_REALTIME) && hw_enable
                            && !standby_q && !float_q;
    assign out_float      = float_q && hw_enable && !standby_q;
    assign out_pulldown   = !hw_enable || standby_q;
    assign seq_busy       = (state_q != HPS_IDLE);

endmodule // hps_sequencer

/* sim/hps_lib_model.sv */
`timescale 1ns/1ps
module hps_lib_model (
    input  logic       clk,
    input  logic       lib_start,
    input  logic [6:0] lib_index,
    input  logic       lib_abort,
    input  int         dly,
    output logic       lib_done
);
    logic [6:0] idx_log [64];
    int         t_log [64];
    int         n_start = 0;
    int         n_abort = 0;
    int         cnt = 0;
    int         cyc = 0;

    initial lib_done = 1'b0;

    // Plays each started waveform for dly cycles, logs it, and stops early on abort.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        lib_done <= 1'b0;
        if (lib_abort === 1'b1) begin
            n_abort <= n_abort + 1;
            cnt <= 0;
        end else if (lib_start === 1'b1) begin
            idx_log[n_start] <= lib_index;
            t_log[n_start] <= cyc;
            n_start <= n_start + 1;
            cnt <= dly;
        end else if (cnt == 1) begin
            lib_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // hps_lib_model

/* sim/hps_sequencer_asserts.sv */
`timescale 1ns/1ps
module hps_seq_asserts #(
    parameter int WAIT_UNIT_CYCLES = 4
) (
    input logic       clk,
    input logic       resetn,
    input logic       hw_enable,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_we,
    input logic       reg_re,
    input logic [7:0] reg_rdata,
    input logic       reg_rvalid,
    input logic [7:0] drive_value,
    input logic       drive_unsigned,
    input logic       drive_active,
    input logic       out_float,
    input logic       out_pulldown,
    input logic       lib_start,
    input logic [6:0] lib_index,
    input logic       lib_abort,
    input logic       lib_done,
    input logic       seq_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Output stage states, register bus answers and sequencer strobes tied to their causes.
    AST_FLOAT_PULL: assert property (out_float |-> hw_enable && !out_pulldown)
        else $error("float while not enabled");
    AST_DRIVE_FLOAT: assert property (drive_active |-> !out_float && !out_pulldown)
        else $error("drive while floating");
    AST_SHUTDOWN: assert property (!hw_enable |-> out_pulldown && !drive_active)
        else $error("shutdown not pulled down");
    AST_RT_WRITE: assert property (reg_we && reg_addr == hps_pkg::RT_DRIVE_ADDR
        |=> drive_value == $past(reg_wdata)) else $error("drive value not applied");
    AST_FORMAT: assert property (reg_we && reg_addr == hps_pkg::FORMAT_CTRL_ADDR
        |=> drive_unsigned == $past(reg_wdata[3])) else $error("format bit not applied");
    AST_RVALID: assert property (reg_rvalid == $past(reg_re))
        else $error("read valid misplaced");
    AST_START_ONE: assert property (lib_start |=> !lib_start && seq_busy)
        else $error("start pulse too long");
    AST_CANCEL: assert property ($fell(hw_enable) |-> ##[1:2] !seq_busy)
        else $error("shutdown did not cancel");
    AST_ABORT: assert property (lib_abort |-> !seq_busy && !lib_start)
        else $error("abort while busy");
endmodule // hps_seq_asserts

bind hps_sequencer hps_seq_asserts #(.WAIT_UNIT_CYCLES(WAIT_UNIT_CYCLES)) hps_seq_asserts_i (
    .clk(clk), .resetn(resetn), .hw_enable(hw_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .drive_value(drive_value), .drive_unsigned(drive_unsigned),
    .drive_active(drive_active), .out_float(out_float), .out_pulldown(out_pulldown),
    .lib_start(lib_start), .lib_index(lib_index), .lib_abort(lib_abort),
    .lib_done(lib_done), .seq_busy(seq_busy));

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       hw_enable = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_we = 1'b0;
    logic       reg_re = 1'b0;
    logic [7:0] reg_rdata, drive_value, rd_q;
    logic [6:0] lib_index;
    logic       reg_rvalid, drive_unsigned, drive_active, out_float, out_pulldown;
    logic       lib_start, lib_abort, lib_done, seq_busy;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         dly = 3;
    int         gap;

    always #5 clk = ~clk;

    hps_sequencer #(.WAIT_UNIT_CYCLES(4)) hps_sequencer_i (.clk(clk), .resetn(resetn),
        .hw_enable(hw_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .drive_value(drive_value), .drive_unsigned(drive_unsigned),
        .drive_active(drive_active), .out_float(out_float), .out_pulldown(out_pulldown),
        .lib_start(lib_start), .lib_index(lib_index), .lib_abort(lib_abort),
        .lib_done(lib_done), .seq_busy(seq_busy));
    hps_lib_model hps_lib_model_i (.clk(clk), .lib_start(lib_start), .lib_index(lib_index),
        .lib_abort(lib_abort), .dly(dly), .lib_done(lib_done));

    // Compares one result byte or flag and counts it.
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Register bus write and read; the read waits out the one-cycle answer.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        rd_q = reg_rdata;
        chk_val(reg_rvalid, 1'b1);
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clk);
            #1;
            if (seq_busy === 1'b0) return;
        end
        n_mismatch++;
        print_verdict;
    endtask

    // Loads all slots, fires, and compares the played indices with the slot walk.
    task automatic play(input logic [7:0] s [8]);
        logic [6:0] e [$];
        int n;
        n = hps_lib_model_i.n_start;
        for (int k = 0; k < 8; k++) wr(8'h04 + 8'(k), s[k]);
        for (int k = 0; k < 8; k++) begin
            if (s[k][6:0] == 7'h00) break;
            if (!s[k][7]) e.push_back(s[k][6:0]);
        end
        wr(8'h0c, 8'h01);
        wait_idle();
        chk_val(8'(hps_lib_model_i.n_start - n), 8'(e.size()));
        foreach (e[i]) chk_val(hps_lib_model_i.idx_log[n + i], e[i]);
        rd(8'h0c);
        chk_val(rd_q, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h01);
        chk_val(rd_q, 8'h40);
        rd(8'h02);
        chk_val(rd_q, 8'h00);
        rd(8'h20);
        chk_val(rd_q, 8'h00);
        chk_val(out_pulldown, 1'b1);
        $display("test reset done");
        wr(8'h01, 8'h05);
        wr(8'h02, 8'h80);
        chk_val(drive_value, 8'h80);
        chk_val(drive_active, 1'b1);
        chk_val(drive_unsigned, 1'b0);
        wr(8'h1d, 8'h08);
        chk_val(drive_unsigned, 1'b1);
        wr(8'h02, 8'h7f);
        chk_val(drive_value, 8'h7f);
        wr(8'h0c, 8'h01);
        rd(8'h0c);
        chk_val(rd_q, 8'h00);
        wr(8'h03, 8'h10);
        chk_val(out_float, 1'b1);
        chk_val(drive_active, 1'b0);
        rd(8'h03);
        chk_val(rd_q, 8'h10);
        wr(8'h01, 8'h45);
        chk_val(out_float, 1'b0);
        chk_val(out_pulldown, 1'b1);
        wr(8'h01, 8'h05);
        @(posedge clk);
        hw_enable <= 1'b0;
        @(posedge clk);
        #1;
        chk_val({out_float, out_pulldown}, 8'h01);
        @(posedge clk);
        hw_enable <= 1'b1;
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h00);
        $display("test realtime done");
        play('{8'h03, 8'h82, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        gap = hps_lib_model_i.t_log[1] - hps_lib_model_i.t_log[0];
        chk_val(gap >= dly + 10 && gap <= dly + 15, 1'b1);
        play('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
        play('{8'h05, 8'h80, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        rd(8'h05);
        chk_val(rd_q, 8'h80);
        $display("test sequence done");
        dly = 60;
        wr(8'h04, 8'h09);
        wr(8'h0c, 8'h01);
        repeat (10) @(posedge clk);
        wr(8'h0c, 8'h00);
        wait_idle();
        chk_val(8'(hps_lib_model_i.n_abort), 8'h01);
        $display("test cancel done");
        print_verdict;
    end
endmodule // testbench
